// >>> logic/iopd_decode.sv
/*
 Address decoder: forms the port address and gives a one-hot select over
 the defined registers. Combinational; assumes inputs are from the core clock.
*/
`timescale 1ns/10ps
module iopd_decode
   import iopd_pkg::*;
(
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_xreg,
   input wire logic i_indexed,
   output logic [7:0] o_port,
   output logic [IOPD_NREG-1:0] o_sel
);
   localparam logic [7:0] MAP [IOPD_NREG] = '{IOPD_A_BANK0, IOPD_A_BANK1, IOPD_A_MASK0,
      IOPD_A_MASK1, IOPD_A_PINDRV, IOPD_A_TWPOS, IOPD_A_FADDR, IOPD_A_EP0CNT,
      IOPD_A_EP0SET, IOPD_A_EP1CNT, IOPD_A_EP1SET};

   // Sum wraps in 8 bits; with a zero field only X remains
   assign o_port = i_indexed ? 8'(i_addr + i_xreg) : i_addr;

   genvar g;
   generate
      for (g = 0; g < IOPD_NREG; g++) begin : g_sel
         assign o_sel[g] = (o_port == MAP[g]);
      end
   endgenerate
endmodule

// >>> logic/iopd_pkg.sv
/*
 Package for the I/O port decode block: port addresses, widths, reset
 values and the access carrier. Assumes an 8-bit port space.
*/
package iopd_pkg;
   localparam int IOPD_AW = 8;
   localparam int IOPD_DW = 8;
   localparam logic [7:0] IOPD_A_BANK0 = 8'h00;
   localparam logic [7:0] IOPD_A_BANK1 = 8'h01;
   localparam logic [7:0] IOPD_A_MASK0 = 8'h04;
   localparam logic [7:0] IOPD_A_MASK1 = 8'h05;
   localparam logic [7:0] IOPD_A_PINDRV = 8'h08;
   localparam logic [7:0] IOPD_A_TWPOS = 8'h09;
   localparam logic [7:0] IOPD_A_FADDR = 8'h10;
   localparam logic [7:0] IOPD_A_EP0CNT = 8'h11;
   localparam logic [7:0] IOPD_A_EP0SET = 8'h12;
   localparam logic [7:0] IOPD_A_EP1CNT = 8'h13;
   localparam logic [7:0] IOPD_A_EP1SET = 8'h14;
   localparam int IOPD_NREG = 11;
   localparam logic [7:0] IOPD_RST_VAL = 8'h00;
   localparam logic [7:0] IOPD_RD_NONE = 8'h00;

   typedef enum logic [2:0] {
      IOPD_OP_NONE = 3'b001,
      IOPD_OP_READ = 3'b010,
      IOPD_OP_WRITE = 3'b100
   } iopd_op_type;

   // One instruction issued by the core
   typedef struct packed {
      logic rd;
      logic wr;
      logic indexed;
      logic [7:0] addr;
      logic [7:0] xreg;
      logic [7:0] acc;
   } iopd_req_type;
endpackage

// >>> logic/iopd_top.sv
/*
 I/O port register bank: decodes core port reads and writes and holds the
 low register map. Assumes requests are one-cycle pulses on the core clock.
*/
// How it works
// - Port read returns the addressed register for the accumulator; masks and unmapped ports read zero.
// - Direct write stores the accumulator at the instruction address.
// - Indexed write targets instruction address plus X.
// - Indexed write with zero field selects by X alone.
// - GPIO bank data registers at 0x00 and 0x01, read/write.
// - GPIO interrupt masks at 0x04 and 0x05, write only.
// - Pin drive setup at 0x08, two-wire position at 0x09, read/write.
// - USB address 0x10, endpoint zero count 0x11 and setup 0x12.
// - Endpoint one count at 0x13, read/write.
// - Endpoint one setup at 0x14, read/write.
`timescale 1ns/10ps
module iopd_top
   import iopd_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire iopd_req_type i_req,
   output logic o_rd_valid,
   output logic [7:0] o_rd_data,
   output logic [7:0] o_bank0,
   output logic [7:0] o_bank1,
   output logic [7:0] o_mask0,
   output logic [7:0] o_mask1,
   output logic [7:0] o_pin_drive,
   output logic [7:0] o_two_wire_pos,
   output logic [7:0] o_usb_addr,
   output logic [7:0] o_ep0_count,
   output logic [7:0] o_ep0_setup,
   output logic [7:0] o_ep1_count,
   output logic [7:0] o_ep1_setup
);
   //------------------------------------------
   // Reset release
   //------------------------------------------
   logic rst_s1_r;
   logic rst_n_r;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   //------------------------------------------
   // Decode
   //------------------------------------------
   logic [7:0] port;
   logic [IOPD_NREG-1:0] sel;
   iopd_op_type op;
   logic [7:0] regs_r [IOPD_NREG];

   iopd_decode u_dec (
      .i_addr(i_req.addr),
      .i_xreg(i_req.xreg),
      .i_indexed(i_req.indexed & i_req.wr),
      .o_port(port),
      .o_sel(sel)
   );

   // Read wins nothing over write: a request with both is treated as write
   always_comb begin
      if (i_req.wr) begin
         op = IOPD_OP_WRITE;
      end else if (i_req.rd) begin
         op = IOPD_OP_READ;
      end else begin
         op = IOPD_OP_NONE;
      end
   end

   //------------------------------------------
   // Register store
   //------------------------------------------
   // Reserved bits are stored as given; software keeps them zero
   genvar g;
   generate
      for (g = 0; g < IOPD_NREG; g++) begin : g_reg
         always_ff @(posedge i_clk or negedge rst_n_r) begin
            if (!rst_n_r) begin
               regs_r[g] <= IOPD_RST_VAL;
            end else if (i_ce && op == IOPD_OP_WRITE && sel[g]) begin
               regs_r[g] <= i_req.acc;
            end
         end
      end
   endgenerate

   //------------------------------------------
   // Read path
   //------------------------------------------
   logic [7:0] rd_nxt;
   always_comb begin
      rd_nxt = IOPD_RD_NONE;
      for (int k = 0; k < IOPD_NREG; k++) begin
         // Mask registers are write only and read as zero
         if (sel[k] && k != 2 && k != 3) begin
            rd_nxt = regs_r[k];
         end
      end
   end

   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_rd_valid <= 1'b0;
         o_rd_data <= IOPD_RD_NONE;
      end else if (i_ce) begin
         o_rd_valid <= (op == IOPD_OP_READ);
         if (op == IOPD_OP_READ) begin
            o_rd_data <= rd_nxt;
         end
      end
   end

   //------------------------------------------
   // Register outputs
   //------------------------------------------
   assign o_bank0 = regs_r[0];
   assign o_bank1 = regs_r[1];
   assign o_mask0 = regs_r[2];
   assign o_mask1 = regs_r[3];
   assign o_pin_drive = regs_r[4];
   assign o_two_wire_pos = regs_r[5];
   assign o_usb_addr = regs_r[6];
   assign o_ep0_count = regs_r[7];
   assign o_ep0_setup = regs_r[8];
   assign o_ep1_count = regs_r[9];
   assign o_ep1_setup = regs_r[10];

   //------------------------------------------
   // Assertions
   //------------------------------------------
   sequence s_dir_write(logic [7:0] a);
      i_ce && i_req.wr && !i_req.indexed && i_req.addr == a;
   endsequence

   // Reads ignore the index field, so it is left out here
   sequence s_port_read(logic [7:0] a);
      i_ce && i_req.rd && !i_req.wr && i_req.addr == a;
   endsequence

   direct_write_a: assert property (@(posedge i_clk) disable iff (!rst_n_r)
      s_dir_write(IOPD_A_BANK0) |=> o_bank0 == $past(i_req.acc))
      else $error("direct write to bank zero lost");

   indexed_sum_a: assert property (@(posedge i_clk) disable iff (!rst_n_r)
      i_ce && i_req.wr && i_req.indexed && 8'(i_req.addr + i_req.xreg) == IOPD_A_FADDR
      |=> o_usb_addr == $past(i_req.acc))
      else $error("indexed write missed summed address");

   index_zero_a: assert property (@(posedge i_clk) disable iff (!rst_n_r)
      i_ce && i_req.wr && i_req.indexed && i_req.addr == 8'h00 && i_req.xreg == IOPD_A_EP1SET
      |=> o_ep1_setup == $past(i_req.acc))
      else $error("zero field indexed write wrong");

   read_back_a: assert property (@(posedge i_clk) disable iff (!rst_n_r)
      i_ce && i_req.rd && !i_req.wr && i_req.addr == IOPD_A_EP0CNT
      |=> o_rd_valid && o_rd_data == $past(o_ep0_count))
      else $error("read data mismatch");

   mask_read_a: assert property (@(posedge i_clk) disable iff (!rst_n_r)
      i_ce && i_req.rd && !i_req.wr && i_req.addr == IOPD_A_MASK0 |=> o_rd_data == 8'h00)
      else $error("write only mask readable");

   unmapped_read_a: assert property (@(posedge i_clk) disable iff (!rst_n_r)
      i_ce && i_req.rd && !i_req.wr && i_req.addr == 8'h02 |=> o_rd_data == 8'h00)
      else $error("unmapped read not zero");

   unmapped_write_a: assert property (@(posedge i_clk) disable iff (!rst_n_r)
      i_ce && i_req.wr && !i_req.indexed && i_req.addr == 8'h0a
      |=> $stable({o_bank0, o_bank1, o_mask0, o_mask1, o_pin_drive, o_two_wire_pos, o_usb_addr,
         o_ep0_count, o_ep0_setup, o_ep1_count, o_ep1_setup}))
      else $error("unmapped write changed register");

   freeze_a: assert property (@(posedge i_clk) disable iff (!rst_n_r)
      !i_ce |=> $stable(o_pin_drive) && $stable(o_rd_valid))
      else $error("state moved with enable low");

   rd_pulse_a: assert property (@(posedge i_clk) disable iff (!rst_n_r)
      i_ce && !(i_req.rd && !i_req.wr) |=> !o_rd_valid)
      else $error("read valid without read");

   rd_hold_a: assert property (@(posedge i_clk) disable iff (!rst_n_r)
      i_ce && !(i_req.rd && !i_req.wr) |=> $stable(o_rd_data))
      else $error("read data moved without read");

   indexed_read_a: assert property (@(posedge i_clk) disable iff (!rst_n_r)
      s_port_read(IOPD_A_BANK1) ##0 i_req.indexed |=> o_rd_valid && o_rd_data == $past(o_bank1))
      else $error("indexed read used summed address");

   // Both strobes at once: the write is kept and no read answer follows
   both_write_a: assert property (@(posedge i_clk) disable iff (!rst_n_r)
      i_ce && i_req.rd && i_req.wr && !i_req.indexed && i_req.addr == IOPD_A_PINDRV
      |=> o_pin_drive == $past(i_req.acc) && !o_rd_valid)
      else $error("write with read strobe lost");

   bank1_write_a: assert property (@(posedge i_clk) disable iff (!rst_n_r)
      s_dir_write(IOPD_A_BANK1) |=> o_bank1 == $past(i_req.acc))
      else $error("direct write to bank one lost");

   mask_write_a: assert property (@(posedge i_clk) disable iff (!rst_n_r)
      s_dir_write(IOPD_A_MASK1) |=> o_mask1 == $past(i_req.acc))
      else $error("mask write lost");

   two_wire_write_a: assert property (@(posedge i_clk) disable iff (!rst_n_r)
      s_dir_write(IOPD_A_TWPOS) |=> o_two_wire_pos == $past(i_req.acc))
      else $error("two-wire position write lost");

   usb_addr_write_a: assert property (@(posedge i_clk) disable iff (!rst_n_r)
      s_dir_write(IOPD_A_FADDR) |=> o_usb_addr == $past(i_req.acc))
      else $error("function address write lost");

   ep1_count_a: assert property (@(posedge i_clk) disable iff (!rst_n_r)
      s_dir_write(IOPD_A_EP1CNT) |=> o_ep1_count == $past(i_req.acc))
      else $error("endpoint one count write lost");

   ep1_setup_a: assert property (@(posedge i_clk) disable iff (!rst_n_r)
      s_dir_write(IOPD_A_EP1SET) |=> o_ep1_setup == $past(i_req.acc))
      else $error("endpoint one setup write lost");
endmodule

// >>> tb/iopd_core_model.sv
/*
 Core model: issues port reads, direct and indexed writes as one-cycle requests.
 Assumes a free-running clock and that the bench calls issue after reset.
*/
`timescale 1ns/10ps
module iopd_core_model
   import iopd_pkg::*;
(
   input wire logic i_clk,
   output iopd_req_type o_req,
   output logic o_ce
);
   initial begin
      o_req = '0;
      o_ce = 1'b1;
   end
   // Unmapped addresses come only from scenarios probing refusal
   task automatic issue(input logic rd, wr, ix, input logic [7:0] a, x, v);
      @(negedge i_clk);
      o_req = '{rd: rd, wr: wr, indexed: ix, addr: a, xreg: x, acc: v};
      @(negedge i_clk);
      // Stale fields are inverted so a leftover value never passes for a live one
      o_req = '{rd: 1'b0, wr: 1'b0, indexed: ~ix, addr: ~a, xreg: ~x, acc: ~v};
   endtask
   // Called at a falling edge so the enable settles before the next rising one
   task automatic set_ce(input logic v);
      o_ce = v;
   endtask
endmodule

// >>> tb/tb_iopd_top.sv
/*
 Testbench for the port register bank: register tasks, read-back and refusals.
 Assumes the core model drives every request field and the clock enable.
*/
`timescale 1ns/10ps
module tb_iopd_top;
   import iopd_pkg::*;
   logic i_clk, i_resetn, i_ce, o_rd_valid;
   iopd_req_type i_req;
   logic [7:0] o_rd_data;
   wire [87:0] outs;
   logic [7:0] regs [11];
   logic [7:0] amap [11];
   int err_total, cmp_count;
   iopd_core_model core (.i_clk(i_clk), .o_req(i_req), .o_ce(i_ce));
   iopd_top uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_req(i_req),
      .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_bank0(outs[7:0]), .o_bank1(outs[15:8]),
      .o_mask0(outs[23:16]), .o_mask1(outs[31:24]), .o_pin_drive(outs[39:32]),
      .o_two_wire_pos(outs[47:40]), .o_usb_addr(outs[55:48]), .o_ep0_count(outs[63:56]),
      .o_ep0_setup(outs[71:64]), .o_ep1_count(outs[79:72]), .o_ep1_setup(outs[87:80]));
   // ----------------------------------------
   // Compare and access tasks
   // ----------------------------------------
   task automatic chk8(input logic [7:0] got, exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic chk1(input logic got, exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s flag %b", $time, m, got);
      end
   endtask
   task automatic wr(input logic ix, input logic [7:0] a, x, v);
      logic [7:0] t;
      t = ix ? a + x : a;
      core.issue(1'b0, 1'b1, ix, a, x, v);
      for (int i = 0; i < 11; i++) if (amap[i] === t) regs[i] = v;
   endtask
   task automatic rd(input logic [7:0] a, exp);
      core.issue(1'b1, 1'b0, 1'b0, a, 8'h00, 8'h5a);
      chk1(o_rd_valid, 1'b1, "read valid");
      chk8(o_rd_data, exp, "read data");
   endtask
   task automatic chk_regs;
      for (int i = 0; i < 11; i++) chk8(outs[8*i+:8], regs[i], "register");
   endtask
   task automatic rd_all;
      for (int i = 0; i < 11; i++) rd(amap[i], (i == 2 || i == 3) ? 8'h00 : regs[i]);
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   initial begin
      #200000;
      err_total++;
      $display("unexpected at %0t: run too long", $time);
      wrap_up();
   end
   initial begin
      amap = '{IOPD_A_BANK0, IOPD_A_BANK1, IOPD_A_MASK0, IOPD_A_MASK1, IOPD_A_PINDRV, IOPD_A_TWPOS,
         IOPD_A_FADDR, IOPD_A_EP0CNT, IOPD_A_EP0SET, IOPD_A_EP1CNT, IOPD_A_EP1SET};
      regs = '{default: 8'h00};
      i_resetn = 1'b0;
      repeat (3) @(negedge i_clk);
      i_resetn = 1'b1;
      repeat (3) @(negedge i_clk);
      chk_regs();
      rd_all();
      $display("test reset done");
      for (int i = 0; i < 11; i++) wr(1'b0, amap[i], 8'h00, 8'ha0 + 8'(i));
      chk_regs();
      rd_all();
      $display("test direct done");
      wr(1'b1, 8'h0f, 8'h02, 8'h3c);
      wr(1'b1, 8'h00, 8'h13, 8'h77);
      wr(1'b1, 8'h00, IOPD_A_EP1SET, 8'h5e);
      wr(1'b1, 8'hf0, 8'h20, 8'h99);
      chk_regs();
      // Last read was the endpoint one setup register, written with 0xaa above
      chk8(o_rd_data, 8'haa, "read data held");
      $display("test indexed done");
      wr(1'b0, 8'h02, 8'h00, 8'hff);
      wr(1'b0, 8'h0a, 8'h00, 8'hff);
      wr(1'b1, 8'h30, 8'h04, 8'hff);
      rd(8'h02, 8'h00);
      rd(8'h15, 8'h00);
      chk_regs();
      // Let the read pulse end first, or the freeze would hold it high
      @(negedge i_clk);
      chk1(o_rd_valid, 1'b0, "read pulse end");
      core.set_ce(1'b0);
      core.issue(1'b0, 1'b1, 1'b0, 8'h00, 8'h00, 8'h11);
      core.issue(1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
      chk1(o_rd_valid, 1'b0, "frozen read");
      core.set_ce(1'b1);
      chk_regs();
      core.issue(1'b1, 1'b1, 1'b0, IOPD_A_PINDRV, 8'h00, 8'h6b);
      regs[4] = 8'h6b;
      chk1(o_rd_valid, 1'b0, "read with write");
      chk_regs();
      core.issue(1'b1, 1'b0, 1'b1, IOPD_A_BANK1, 8'h07, 8'h00);
      chk8(o_rd_data, regs[1], "indexed read");
      $display("test refusal done");
      i_resetn = 1'b0;
      @(negedge i_clk);
      regs = '{default: 8'h00};
      chk_regs();
      chk8(o_rd_data, 8'h00, "reset read data");
      i_resetn = 1'b1;
      repeat (3) @(negedge i_clk);
      rd_all();
      $display("test second reset done");
      wrap_up();
   end
endmodule
